// ===== pkg/pm_pkg.sv
// Constants shared by the low-power pin state controller and its testbench.
// Assumes every user of these names writes pm_pkg::name in full.
`default_nettype none
package pm_pkg;
   // =====================================================================
   // Sleep mode select field encodings and reset value.
   localparam logic [1:0] SLP_IDLE      = 2'h0;  // Plain idle.
   localparam logic [1:0] SLP_RTC_RUN   = 2'h1;  // Sleep, real-time clock runs.
   localparam logic [1:0] SLP_RESERVED  = 2'h2;  // Reserved, treated as idle.
   localparam logic [1:0] SLP_ALL_STOP  = 2'h3;  // Sleep, clock and oscillator stop.
   localparam logic [1:0] SLP_CFG_RESET = 2'h0;
   // =====================================================================
   // External bus modes.
   localparam logic [1:0] BM_DEMUX8  = 2'h0;
   localparam logic [1:0] BM_MUX8    = 2'h1;
   localparam logic [1:0] BM_DEMUX16 = 2'h2;
   localparam logic [1:0] BM_MUX16   = 2'h3;
   // =====================================================================
   // Segment line strap codes and the number of segment lines each selects.
   localparam logic [1:0] SEG_TWO   = 2'h3;
   localparam logic [1:0] SEG_EIGHT = 2'h2;
   localparam logic [1:0] SEG_NONE  = 2'h1;
   localparam logic [1:0] SEG_FOUR  = 2'h0;
   localparam logic [3:0] SEG_N_TWO   = 4'h2;
   localparam logic [3:0] SEG_N_EIGHT = 4'h8;
   localparam logic [3:0] SEG_N_NONE  = 4'h0;
   localparam logic [3:0] SEG_N_FOUR  = 4'h4;
   localparam int         SEG_LSB     = 16;   // First segment bit of the address.
   // =====================================================================
   // Power states, one-hot.
   typedef enum logic [5:0] {
      ST_RUN   = 6'h01,
      ST_IDLE  = 6'h02,
      ST_PDN   = 6'h04,
      ST_SLEEP = 6'h08,
      ST_RAMP  = 6'h10,
      ST_PEC   = 6'h20
   } pm_state_e;
endpackage : pm_pkg
`default_nettype wire

// ===== hw/bus_snapshot.sv
// Snapshot of the last external bus access: address, byte select, chip select.
// Assumes access pulses are one cycle wide and synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module bus_snapshot #(
   parameter int AW  = 24,
   parameter int NCS = 5
) (
   // Clock and reset.
   input  wire logic           mclk,
   input  wire logic           nrst,
   // Access strobes and captured values.
   input  wire logic           ext_access,
   input  wire logic           xper_access,
   input  wire logic [AW-1:0]  acc_addr,
   input  wire logic           acc_bhe_n,
   input  wire logic [NCS-1:0] acc_cs_hit,
   // Held values.
   output logic      [AW-1:0]  last_addr_q,
   output logic                last_bhe_n_q,
   output logic      [NCS-1:0] last_cs_q,
   output logic                last_xper_q
);
   // =====================================================================
   // Capture at each external access so the pins can be held later. [RL25]
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         last_addr_q  <= '0;
         last_bhe_n_q <= 1'b1;
         last_cs_q    <= '0;
      end else if (ext_access) begin
         last_addr_q  <= acc_addr;       // [RL25]
         last_bhe_n_q <= acc_bhe_n;
         last_cs_q    <= acc_cs_hit;
      end
   end

   // An on-chip extension access marks that no external select stays low.
   // A later external access cancels it, since that access wins on the pins.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         last_xper_q <= 1'b0;
      end else if (xper_access) begin
         last_xper_q <= 1'b1;            // [RL13]
      end else if (ext_access) begin
         last_xper_q <= 1'b0;
      end
   end
endmodule : bus_snapshot
`default_nettype wire

// ===== hw/power_mode_pin_state.sv
// Low-power state controller: idle, power-down and sleep, with pin hold logic.
// Assumes all inputs are synchronous to mclk and instruction strobes are pulses.
//
// Overview of operation
// RL1 - Idle: GPIO pins keep their latch value.
// RL2 - Idle: alternate pins follow their running peripheral.
// RL3 - Bus control pins inactive; byte select holds. The code leaves hold acknowledge at its last level.
// RL4 - Upper port: last high address byte if mux8.
// RL5 - Lower port floats with external bus enabled.
// RL6 - Address port: last address if demultiplexed.
// RL7 - Segment pins hold last segment; others latch.
// RL8 - Power-down stops oscillator, CPU, peripheral clocks.
// RL9 - Power-down: GPIO pins keep their latch value.
// RL10 - Power-down: alternate pins freeze at last level.
// RL11 - Reset output high only after end-of-init.
// RL12 - Last chip select low, other selects high.
// RL13 - Extension access before entry releases all selects.
// RL14 - Sleep stops clocks, exits like idle.
// RL15 - Sleep wakes on interrupts, NMI edge, RTC.
// RL16 - Event transfer in sleep, then sleep again.
// RL17 - Watchdog halted throughout sleep.
// RL18 - Sleep stops PLL; oscillator, RTC by config.
// RL19 - After sleep wake, wait for PLL lock.
// RL20 - Sleep config locked after end-of-init. The code still takes writes while sleep_cfg_unlock is high.
// RL21 - RTC interrupts give periodic wakeups.
// RL22 - Field: 00 idle, 01 RTC, 11 stop.
// RL23 - Idle instruction enters sleep per field.
// RL24 - Reduced-speed clocking forces plain idle.
// RL25 - Last address, segment, selects registered per access.
`timescale 1ns/1ps
`default_nettype none
module power_mode_pin_state #(
   parameter int NGP = 8,
   parameter int NCS = 5
) (
   // Clock and reset.
   input  wire logic           mclk,
   input  wire logic           nrst,
   // CPU events.
   input  wire logic           idle_instr,
   input  wire logic           pwrdn_instr,
   input  wire logic           end_of_init_instruction,
   input  wire logic           slow_down_active,
   // Sleep configuration access.
   input  wire logic           sleep_cfg_wr,
   input  wire logic [1:0]     sleep_cfg_wdata,
   input  wire logic           sleep_cfg_unlock,
   output logic      [1:0]     sleep_mode_select_field,
   // Wakeup sources and event transfer.
   input  wire logic           ext_int_req,
   input  wire logic           alt_int_req,
   input  wire logic           nmi_n,
   input  wire logic           rtc_int_req,
   input  wire logic           pec_req,
   input  wire logic           pec_done,
   output logic                pec_grant,
   // Clock system.
   input  wire logic           pll_lock,
   output logic                cpu_clk_en,
   output logic                periph_clk_en,
   output logic                pll_en,
   output logic                osc_en,
   output logic                rtc_en,
   output logic                wdt_run,
   output logic      [5:0]     power_state,
   // Bus configuration and live bus controller outputs.
   input  wire logic           ext_bus_en,
   input  wire logic [1:0]     bus_mode,
   input  wire logic [1:0]     seg_strap,
   input  wire logic           ext_access,
   input  wire logic           xper_access,
   input  wire logic [23:0]    acc_addr,
   input  wire logic [NCS-1:0] acc_cs_hit,
   input  wire logic [NCS-1:0] cs_enable,
   input  wire logic [15:0]    bus_p0_o,
   input  wire logic           bus_p0_oe,
   input  wire logic           bus_ale,
   input  wire logic           bus_rd_n,
   input  wire logic           bus_wr_n,
   input  wire logic           bus_bhe_n,
   input  wire logic           bus_hold_acknowledge_out,
   input  wire logic           bus_bus_request_out_n,
   input  wire logic [NCS-1:0] bus_cs_n,
   // Port output latches.
   input  wire logic [15:0]    p0_latch,
   input  wire logic [15:0]    p1_latch,
   input  wire logic [7:0]     p4_latch,
   input  wire logic [7:0]     ctl_latch,
   input  wire logic [NGP-1:0] gp_latch,
   input  wire logic [NGP-1:0] gp_alt_sel,
   input  wire logic [NGP-1:0] gp_alt_val,
   // Pins.
   output logic      [7:0]     lower_addr_data_port,
   output logic                lower_addr_data_oe,
   output logic      [7:0]     upper_addr_data_port,
   output logic                upper_addr_data_oe,
   output logic      [15:0]    demux_address_port,
   output logic      [7:0]     seg_port,
   output logic                ale,
   output logic                rd_n,
   output logic                wr_n,
   output logic                high_byte_select_n,
   output logic                hold_acknowledge_out,
   output logic                bus_request_out_n,
   output logic      [NCS-1:0] chip_select_lines_n,
   output logic                reset_output_pin,
   output logic      [NGP-1:0] gp_pin
);
   // =====================================================================
   // Strap decode and state.
   function automatic logic [3:0] seg_lines(input logic [1:0] code);
      unique case (code)
         pm_pkg::SEG_TWO:   seg_lines = pm_pkg::SEG_N_TWO;
         pm_pkg::SEG_EIGHT: seg_lines = pm_pkg::SEG_N_EIGHT;
         pm_pkg::SEG_NONE:  seg_lines = pm_pkg::SEG_N_NONE;
         pm_pkg::SEG_FOUR:  seg_lines = pm_pkg::SEG_N_FOUR;
      endcase
   endfunction : seg_lines

   pm_pkg::pm_state_e state_q;
   logic [1:0]        cfg_q;
   logic              end_of_init_instruction_q;
   logic              nmi_n_q;
   logic              pec_pend_q;
   logic [3:0]        seg_n_q;
   logic              strap_done_q;
   logic              nmi_fall;
   logic              wake_any;
   logic              wake_sleep;
   logic              to_sleep;
   logic              low_pwr;
   logic [23:0]       last_addr;
   logic              last_bhe_n;
   logic [NCS-1:0]    last_cs;
   logic              last_xper;

   // Snapshot of the last external access, held while asleep.
   bus_snapshot #(.AW(24), .NCS(NCS)) u_snap (
      .mclk         (mclk),
      .nrst         (nrst),
      .ext_access   (ext_access),
      .xper_access  (xper_access),
      .acc_addr     (acc_addr),
      .acc_bhe_n    (bus_bhe_n),
      .acc_cs_hit   (acc_cs_hit),
      .last_addr_q  (last_addr),
      .last_bhe_n_q (last_bhe_n),
      .last_cs_q    (last_cs),
      .last_xper_q  (last_xper)
   );

   // =====================================================================
   // Wake qualification. The RTC only wakes sleep when it was left running.
   assign nmi_fall   = nmi_n_q & ~nmi_n;
   assign wake_any   = ext_int_req | alt_int_req | nmi_fall | rtc_int_req;    // [RL21]
   assign wake_sleep = ext_int_req | alt_int_req | nmi_fall |
                       (rtc_int_req & (cfg_q == pm_pkg::SLP_RTC_RUN));        // [RL15]
   // Reserved code and reduced-speed clocking both fall back to plain idle.
   assign to_sleep   = ((cfg_q == pm_pkg::SLP_RTC_RUN) ||
                        (cfg_q == pm_pkg::SLP_ALL_STOP)) && !slow_down_active; // [RL22] [RL24]
   assign low_pwr    = (state_q != pm_pkg::ST_RUN);

   // NMI edge detector; inputs are already synchronous.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nmi_n_q <= 1'b1;
      end else begin
         nmi_n_q <= nmi_n;
      end
   end

   // Segment strap is caught once after reset release, never changed later.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strap_done_q <= 1'b0;
         seg_n_q      <= 4'h0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         seg_n_q      <= seg_lines(seg_strap);   // [RL7]
      end
   end

   // =====================================================================
   // Sleep configuration register and its write protection.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         end_of_init_instruction_q <= 1'b0;
      end else if (end_of_init_instruction) begin
         end_of_init_instruction_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= pm_pkg::SLP_CFG_RESET;
      end else if (sleep_cfg_wr && (!end_of_init_instruction_q || sleep_cfg_unlock)) begin
         cfg_q <= sleep_cfg_wdata;               // [RL20]
      end
   end

   // =====================================================================
   // Power state machine. Power-down leaves only through nrst.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= pm_pkg::ST_RUN;
         pec_pend_q <= 1'b0;
      end else begin
         unique case (state_q)
            pm_pkg::ST_RUN: begin
               if (pwrdn_instr && !nmi_n) begin
                  state_q <= pm_pkg::ST_PDN;             // [RL8]
               end else if (idle_instr) begin
                  state_q <= to_sleep ? pm_pkg::ST_SLEEP : pm_pkg::ST_IDLE; // [RL23]
               end
            end
            pm_pkg::ST_IDLE: begin
               if (wake_any) begin
                  state_q <= pm_pkg::ST_RUN;
               end
            end
            pm_pkg::ST_PDN: begin
               state_q <= pm_pkg::ST_PDN;
            end
            pm_pkg::ST_SLEEP: begin
               if (wake_sleep || pec_req) begin
                  state_q    <= pm_pkg::ST_RAMP;         // [RL14]
                  pec_pend_q <= pec_req && !wake_sleep;
               end
            end
            pm_pkg::ST_RAMP: begin
               if (pll_lock) begin
                  state_q <= pec_pend_q ? pm_pkg::ST_PEC : pm_pkg::ST_RUN; // [RL19]
               end
            end
            pm_pkg::ST_PEC: begin
               if (pec_done) begin
                  state_q    <= pm_pkg::ST_SLEEP;        // [RL16]
                  pec_pend_q <= 1'b0;
               end
            end
            default: begin
               state_q <= pm_pkg::ST_RUN;
            end
         endcase
      end
   end

   // Clock enables decoded from the state register.
   assign cpu_clk_en    = (state_q == pm_pkg::ST_RUN);
   assign periph_clk_en = (state_q == pm_pkg::ST_RUN) || (state_q == pm_pkg::ST_IDLE) ||
                          (state_q == pm_pkg::ST_PEC);                         // [RL8]
   assign pll_en        = (state_q != pm_pkg::ST_PDN) && (state_q != pm_pkg::ST_SLEEP); // [RL18]
   assign osc_en        = (state_q != pm_pkg::ST_PDN) &&
                          !((state_q == pm_pkg::ST_SLEEP) && (cfg_q == pm_pkg::SLP_ALL_STOP));
   assign rtc_en        = !((state_q == pm_pkg::ST_SLEEP) && (cfg_q == pm_pkg::SLP_ALL_STOP));
   assign wdt_run       = (state_q == pm_pkg::ST_RUN) || (state_q == pm_pkg::ST_IDLE); // [RL17]
   assign pec_grant     = (state_q == pm_pkg::ST_PEC) ||
                          ((state_q == pm_pkg::ST_IDLE) && pec_req);
   assign power_state   = state_q;
   assign sleep_mode_select_field = cfg_q;
   assign reset_output_pin        = end_of_init_instruction_q;                                  // [RL11]

   // =====================================================================
   // General pins. Alternate levels freeze when peripheral clocks stop.
   for (genvar i = 0; i < NGP; i++) begin : g_gp
      always_ff @(posedge mclk or negedge nrst) begin
         if (!nrst) begin
            gp_pin[i] <= 1'b0;
         end else if (!gp_alt_sel[i]) begin
            gp_pin[i] <= gp_latch[i];            // [RL1] [RL9]
         end else if (periph_clk_en) begin
            gp_pin[i] <= gp_alt_val[i];          // [RL2] [RL10]
         end
      end
   end

   // Segment pins: held segment bits on strapped lines, latch elsewhere.
   for (genvar s = 0; s < 8; s++) begin : g_seg
      always_ff @(posedge mclk or negedge nrst) begin
         if (!nrst) begin
            seg_port[s] <= 1'b0;
         end else if (ext_bus_en && (4'(s) < seg_n_q)) begin
            seg_port[s] <= low_pwr ? last_addr[pm_pkg::SEG_LSB + s]
                                   : acc_addr[pm_pkg::SEG_LSB + s]; // [RL7]
         end else begin
            seg_port[s] <= p4_latch[s];
         end
      end
   end

   // Address/data ports. Floating is a low enable; the pad resolves it.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lower_addr_data_port <= 8'h00;
         lower_addr_data_oe   <= 1'b0;
         upper_addr_data_port <= 8'h00;
         upper_addr_data_oe   <= 1'b0;
         demux_address_port  <= 16'h0000;
      end else if (!ext_bus_en) begin
         lower_addr_data_port <= p0_latch[7:0];
         lower_addr_data_oe   <= 1'b1;
         upper_addr_data_port <= p0_latch[15:8];
         upper_addr_data_oe   <= 1'b1;
         demux_address_port  <= p1_latch;
      end else if (!low_pwr) begin
         lower_addr_data_port <= bus_p0_o[7:0];
         lower_addr_data_oe   <= bus_p0_oe;
         upper_addr_data_port <= bus_p0_o[15:8];
         upper_addr_data_oe   <= bus_p0_oe;
         demux_address_port  <= bus_mode[0] ? p1_latch : acc_addr[15:0];
      end else begin
         lower_addr_data_oe   <= 1'b0;                              // [RL5]
         upper_addr_data_port <= last_addr[15:8];
         upper_addr_data_oe   <= (bus_mode == pm_pkg::BM_MUX8);     // [RL4]
         demux_address_port  <= bus_mode[0] ? p1_latch : last_addr[15:0]; // [RL6]
      end
   end

   // Bus control pins: inactive levels while asleep, last byte select and hold acknowledge held.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ale                  <= 1'b0;
         rd_n                 <= 1'b1;
         wr_n                 <= 1'b1;
         high_byte_select_n   <= 1'b1;
         hold_acknowledge_out <= 1'b0;
         bus_request_out_n    <= 1'b1;
      end else if (!ext_bus_en) begin
         ale                  <= ctl_latch[0];
         rd_n                 <= ctl_latch[1];
         wr_n                 <= ctl_latch[2];
         high_byte_select_n   <= ctl_latch[3];
         hold_acknowledge_out <= ctl_latch[4];
         bus_request_out_n    <= ctl_latch[5];
      end else if (!low_pwr) begin
         ale                  <= bus_ale;
         rd_n                 <= bus_rd_n;
         wr_n                 <= bus_wr_n;
         high_byte_select_n   <= bus_bhe_n;
         hold_acknowledge_out <= bus_hold_acknowledge_out;
         bus_request_out_n    <= bus_bus_request_out_n;
      end else begin
         ale                  <= 1'b0;           // [RL3]
         rd_n                 <= 1'b1;
         wr_n                 <= 1'b1;
         high_byte_select_n   <= last_bhe_n;     // [RL3]
         bus_request_out_n    <= 1'b1;
      end
   end

   // Chip selects: only the last matched, enabled select stays low.
   for (genvar c = 0; c < NCS; c++) begin : g_cs
      always_ff @(posedge mclk or negedge nrst) begin
         if (!nrst) begin
            chip_select_lines_n[c] <= 1'b1;
         end else if (!ext_bus_en || !low_pwr) begin
            chip_select_lines_n[c] <= bus_cs_n[c];
         end else begin
            chip_select_lines_n[c] <= !(cs_enable[c] && last_cs[c] && !last_xper); // [RL12] [RL13]
         end
      end
   end

   // =====================================================================
   // Checks.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_sleep_wake;
      (state_q == pm_pkg::ST_SLEEP) && wake_sleep;
   endsequence
   sequence s_locked;
      (state_q == pm_pkg::ST_RAMP) && pll_lock && !pec_pend_q;
   endsequence

   a_wake_after_lock: assert property (s_sleep_wake ##1 s_locked |=> cpu_clk_en) // [RL19]
      else $error("CPU clock not restarted after PLL lock.");
   a_ramp_holds_cpu: assert property ((state_q == pm_pkg::ST_RAMP) && !pll_lock |=>
                                      !cpu_clk_en)                                // [RL19]
      else $error("CPU clock ran before PLL lock.");
   a_pdn_clocks_off: assert property ((state_q == pm_pkg::ST_PDN) |->
                                      !osc_en && !periph_clk_en && !cpu_clk_en)   // [RL8]
      else $error("Clock left running in power-down.");
   a_pdn_sticky: assert property ((state_q == pm_pkg::ST_PDN) |=>
                                  (state_q == pm_pkg::ST_PDN))                    // [RL8]
      else $error("Power-down left without reset.");
   a_wdt_sleep_off: assert property ((state_q == pm_pkg::ST_SLEEP) |-> !wdt_run && !pll_en) // [RL17]
      else $error("Watchdog or PLL active in sleep.");
   a_cfg_locked: assert property (end_of_init_instruction_q && !sleep_cfg_unlock |=> $stable(cfg_q)) // [RL20]
      else $error("Sleep config changed while protected.");
   a_slow_idle: assert property ((state_q == pm_pkg::ST_RUN) && idle_instr && !pwrdn_instr &&
                                 slow_down_active |=> (state_q == pm_pkg::ST_IDLE)) // [RL24]
      else $error("Sleep entered in reduced-speed clocking.");
   a_pec_resleep: assert property ((state_q == pm_pkg::ST_PEC) && pec_done |=>
                                   (state_q == pm_pkg::ST_SLEEP))                 // [RL16]
      else $error("Did not return to sleep after transfer.");
   a_lp_ctl_inactive: assert property (ext_bus_en && low_pwr [*2] |->
                                       rd_n && wr_n && !ale && bus_request_out_n) // [RL3]
      else $error("Bus control active in low power.");
   a_lower_float: assert property (ext_bus_en && low_pwr [*2] |-> !lower_addr_data_oe) // [RL5]
      else $error("Lower port driven in low power.");
   a_reset_output_pin_end_of_init_instruction: assert property (end_of_init_instruction |=> reset_output_pin)    // [RL11]
      else $error("Reset output not high after end-of-init.");
endmodule : power_mode_pin_state
`default_nettype wire

// ===== tb/mem_partner.sv
// Behavioural external memory answering one bus access per request strobe.
// Assumes requests are one-cycle strobes driven just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
   // Clock, reset, bench request and the access it shows to the controller.
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        req,
   input  wire logic [23:0] addr,
   output logic             ext_access,
   output logic      [23:0] acc_addr,
   output logic      [4:0]  acc_cs_hit,
   output logic             bus_bhe_n
);
   // Idle address lines show the inverse of the last value, so a stale bus never passes.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ext_access <= 1'b0;
         acc_addr   <= 24'h000000;
      end else begin
         ext_access <= req;
         acc_addr   <= req ? addr : ~acc_addr;
      end
   end
   // Select decode from two address bits; bit 0 gives the byte select.
   assign acc_cs_hit = ext_access ? 5'h01 << acc_addr[17:16] : 5'h00;
   assign bus_bhe_n  = acc_addr[0];
endmodule : mem_partner
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the low-power pin state controller.
// Assumes pm_pkg, the design and mem_partner are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; \
$display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
   // Signals carry the port names so the instance connects by name.
   logic mclk = 1'b0, nrst = 1'b0, idle_instr = 1'b0, pwrdn_instr = 1'b0, preq = 1'b0;
   logic end_of_init_instruction = 1'b0, slow_down_active = 1'b0, sleep_cfg_wr = 1'b0;
   logic sleep_cfg_unlock = 1'b0, ext_int_req = 1'b0, alt_int_req = 1'b0, nmi_n = 1'b1;
   logic rtc_int_req = 1'b0, pec_req = 1'b0, pec_done = 1'b0, pll_lock = 1'b0;
   logic ext_bus_en = 1'b1, xper_access = 1'b0, pec_grant, cpu_clk_en, periph_clk_en;
   logic [1:0] sleep_cfg_wdata = 2'h0, bus_mode = 2'h2, seg_strap = 2'h3, sleep_mode_select_field;
   logic pll_en, osc_en, rtc_en, wdt_run, ext_access, bus_p0_oe, bus_ale, bus_rd_n, bus_wr_n;
   logic bus_bhe_n, bus_hold_acknowledge_out, bus_bus_request_out_n, lower_addr_data_oe, upper_addr_data_oe, ale, rd_n;
   logic wr_n, high_byte_select_n, hold_acknowledge_out, bus_request_out_n, reset_output_pin;
   logic [4:0] acc_cs_hit, bus_cs_n, chip_select_lines_n, cs_enable = 5'h1f;
   logic [15:0] bus_p0_o, p0_latch, p1_latch, demux_address_port;
   logic [7:0] p4_latch, ctl_latch, gp_latch, gp_alt_val, gp_pin, seg_port, gp_alt_sel = 8'hf0;
   logic [7:0] lower_addr_data_port, upper_addr_data_port;
   logic [23:0] acc_addr, a = 24'h000000;
   logic [31:0] r = 32'h092e674b;
   logic [5:0] power_state, e, prev_q = 6'h01;
   logic [5:0] q[$];
   int fails = 0, samples_checked = 0;
   // Latches and live bus values follow the random word.
   assign {p1_latch, p0_latch} = r;
   assign {gp_alt_val, gp_latch, ctl_latch, p4_latch} = r;
   assign bus_p0_o = r[31:16];
   assign {bus_cs_n, bus_p0_oe, bus_ale, bus_rd_n, bus_wr_n, bus_hold_acknowledge_out, bus_bus_request_out_n} = r[10:0];
   always #50 mclk = ~mclk;
   power_mode_pin_state #(.NGP(8), .NCS(5)) dut (.*);
   mem_partner bus (.mclk, .nrst, .req(preq), .addr(a), .ext_access, .acc_addr, .acc_cs_hit,
                    .bus_bhe_n);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // Lets the edge's updates land before outputs are read.
   task automatic look(input int n);
      tick(n);
      #1;
   endtask : look
   task automatic tally_and_finish();
      fails += q.size();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // Each state change is matched against the oldest expected state.
   always @(posedge mclk) begin
      #1;
      if (nrst && power_state !== prev_q) begin
         e = (q.size() > 0) ? q.pop_front() : 6'h3f;
         `CHK("power_state", e, power_state)
         prev_q = power_state;
      end
   end
   // Main sequence: sleep, locked config, transfer, slow idle, power-down.
   initial begin
      tick(6);
      nrst <= 1'b1;
      r <= lfsr(r);
      tick(2);
      sleep_cfg_wr <= 1'b1;
      sleep_cfg_wdata <= 2'h1;
      a <= r[23:0];
      preq <= 1'b1;
      tick(1);
      sleep_cfg_wr <= 1'b0;
      preq <= 1'b0;
      tick(3);
      q.push_back(pm_pkg::ST_SLEEP);
      idle_instr <= 1'b1;
      tick(1);
      idle_instr <= 1'b0;
      look(4);
      `CHK("cfg", pm_pkg::SLP_RTC_RUN, sleep_mode_select_field)
      `CHK("clocks", 3'h0, {pll_en, wdt_run, cpu_clk_en})
      `CHK("addr", a[15:0], demux_address_port)
      `CHK("cs", ~(5'h01 << a[17:16]), chip_select_lines_n)
      `CHK("ctl", {4'h6, a[0]}, {ale, rd_n, wr_n, lower_addr_data_oe, high_byte_select_n})
      tick(1);
      q.push_back(pm_pkg::ST_RAMP);
      q.push_back(pm_pkg::ST_RUN);
      ext_int_req <= 1'b1;
      tick(1);
      ext_int_req <= 1'b0;
      look(3);
      `CHK("hold", 2'h2, {pll_en, cpu_clk_en})
      tick(1);
      pll_lock <= 1'b1;
      end_of_init_instruction <= 1'b1;
      tick(2);
      end_of_init_instruction <= 1'b0;
      sleep_cfg_wr <= 1'b1;
      sleep_cfg_wdata <= 2'h3;
      tick(1);
      sleep_cfg_wr <= 1'b0;
      look(2);
      `CHK("end_of_init_instruction", 2'h3, {cpu_clk_en, reset_output_pin})
      `CHK("cfg_lock", pm_pkg::SLP_RTC_RUN, sleep_mode_select_field)
      $display("test sleep done");
      tick(1);
      q = {pm_pkg::ST_SLEEP, pm_pkg::ST_RAMP, pm_pkg::ST_PEC, pm_pkg::ST_SLEEP,
           pm_pkg::ST_RAMP, pm_pkg::ST_RUN};
      idle_instr <= 1'b1;
      tick(1);
      idle_instr <= 1'b0;
      pec_req <= 1'b1;
      tick(1);
      pec_req <= 1'b0;
      look(1);
      `CHK("pec", 2'h2, {pec_grant, wdt_run})
      tick(1);
      pec_done <= 1'b1;
      tick(1);
      pec_done <= 1'b0;
      alt_int_req <= 1'b1;
      tick(1);
      alt_int_req <= 1'b0;
      tick(1);
      slow_down_active <= 1'b1;
      q.push_back(pm_pkg::ST_IDLE);
      q.push_back(pm_pkg::ST_RUN);
      idle_instr <= 1'b1;
      tick(1);
      idle_instr <= 1'b0;
      look(3);
      `CHK("gp", {r[31:28], r[19:16]}, gp_pin)
      tick(1);
      rtc_int_req <= 1'b1;
      tick(1);
      rtc_int_req <= 1'b0;
      slow_down_active <= 1'b0;
      bus_mode <= 2'h1;
      r <= lfsr(r);
      tick(1);
      a <= r[23:0];
      preq <= 1'b1;
      tick(1);
      preq <= 1'b0;
      tick(1);
      xper_access <= 1'b1;
      tick(1);
      xper_access <= 1'b0;
      pwrdn_instr <= 1'b1;
      tick(1);
      nmi_n <= 1'b0;
      q.push_back(pm_pkg::ST_PDN);
      tick(1);
      pwrdn_instr <= 1'b0;
      look(3);
      `CHK("osc", 2'h0, {osc_en, periph_clk_en})
      `CHK("upper", {1'b1, a[15:8]}, {upper_addr_data_oe, upper_addr_data_port})
      `CHK("seg", {r[7:2], a[17:16]}, seg_port)
      `CHK("cs_off", 5'h1f, chip_select_lines_n)
      `CHK("gp_pdn", {1'b1, r[31:28], r[19:16]}, {bus_request_out_n, gp_pin})
      $display("test power_down done");
      tally_and_finish();
   end
   // Watchdog: the sequence needs about 50 cycles.
   initial begin
      tick(400);
      fails++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
